// ==== shared/chan_pkg.sv ====
package chan_pkg;

    // register offsets on the plain byte port
    localparam logic [2:0] OFS_SC = 3'h0;
    localparam logic [2:0] OFS_MODCTL = 3'h1;
    localparam logic [2:0] OFS_VAL_LO = 3'h2;
    localparam logic [2:0] OFS_VAL_HI = 3'h3;
    localparam logic [2:0] OFS_IRQ_STAT = 3'h4;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h5;

    // channel_status_control fields
    localparam int SC_FLAG = 7;
    localparam int SC_IE = 6;
    localparam int SC_MSU = 5;
    localparam int SC_MSL = 4;
    localparam int SC_ELSU = 3;
    localparam int SC_ELSL = 2;

    // module control field
    localparam int MC_CAS = 5;

    // sticky status / mask field
    localparam int ST_EVENT = 0;

    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [7:0] MODCTL_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [1:0] ELS_GPIO = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;

    typedef enum logic [2:0] {
        MODE_GPIO,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EPWM,
        MODE_CPWM
    } chan_mode_t;

endpackage

// ==== core/timer_channel_control.sv ====
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module timer_channel_control (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // shared counter
    input wire logic [15:0] COUNT,
    input wire logic COUNT_TICK,
    input wire logic COUNT_UP,
    input wire logic [15:0] MODULO,
    output logic UP_DOWN_MODE,
    // channel pin
    input wire logic PIN_IN,
    output logic PIN_OUT,
    output logic PIN_OE,
    // interrupts
    output logic CHAN_IRQ,
    output logic IRQ
);

    function automatic chan_pkg::chan_mode_t decode_mode(
        input logic cas,
        input logic msu,
        input logic msl,
        input logic [1:0] els
    );
        chan_pkg::chan_mode_t m;
        if (els == chan_pkg::ELS_GPIO) begin
            m = chan_pkg::MODE_GPIO;
        end else if (cas) begin
            m = chan_pkg::MODE_CPWM;
        end else if (msu) begin
            m = chan_pkg::MODE_EPWM;
        end else if (msl) begin
            m = chan_pkg::MODE_COMPARE;
        end else begin
            m = chan_pkg::MODE_CAPTURE;
        end
        return m;
    endfunction
    // control state
    logic flag_ff;
    logic ie_ff;
    logic msu_ff;
    logic msl_ff;
    logic [1:0] els_ff;
    logic cas_ff;
    logic armed_ff;
    logic stat_ff;
    logic mask_ff;
    // channel value and byte-pair latching
    logic [15:0] value_ff;
    logic [7:0] wbuf_lo_ff;
    logic [7:0] wbuf_hi_ff;
    logic wlo_seen_ff;
    logic whi_seen_ff;
    logic [7:0] rbuf_ff;
    logic rlatched_ff;
    logic rlatch_hi_ff;
    // pin synchroniser
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic pin_lvl_ff;
    // output flops
    logic [7:0] rdata_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic chan_irq_ff;
    logic irq_ff;
    logic up_down_ff;
    chan_pkg::chan_mode_t mode;
    logic wr_sc;
    logic rd_sc;
    logic pin_rise;
    logic pin_fall;
    logic cap_event;
    logic match;
    logic extreme_duty;
    logic cmp_event;
    logic chan_event;
    logic flag_clear;
    logic nxt_flag;
    logic nxt_ie;
    logic nxt_stat;
    logic nxt_mask;
    logic [7:0] sc_view;
    assign mode = decode_mode(cas_ff, msu_ff, msl_ff, els_ff);
    assign wr_sc = WR && (ADDR == chan_pkg::OFS_SC);
    assign rd_sc = RD && (ADDR == chan_pkg::OFS_SC);
    assign sc_view = {flag_ff, ie_ff, msu_ff, msl_ff, els_ff, 2'h0};

    // edges are taken from the agreed level, never from the first stage
    assign pin_rise = (sync2_ff == sync3_ff) && sync3_ff && !pin_lvl_ff;
    assign pin_fall = (sync2_ff == sync3_ff) && !sync3_ff && pin_lvl_ff;
    always_comb begin
        cap_event = 1'b0;
        if (mode == chan_pkg::MODE_CAPTURE) begin
            unique case (els_ff)
                chan_pkg::ELS_RISE: cap_event = pin_rise;
                chan_pkg::ELS_FALL: cap_event = pin_fall;
                chan_pkg::ELS_BOTH: cap_event = pin_rise || pin_fall;
                default: cap_event = 1'b0;
            endcase
        end
    end

    assign match = COUNT_TICK && (COUNT == value_ff);
    // a value of zero or beyond the modulo holds the output at one level
    assign extreme_duty = (value_ff == 16'h0000) ||
        ((MODULO != 16'h0000) && (value_ff > MODULO));

    always_comb begin
        unique case (mode)
            chan_pkg::MODE_COMPARE: cmp_event = match;
            chan_pkg::MODE_EPWM, chan_pkg::MODE_CPWM: cmp_event = match && !extreme_duty;
            default: cmp_event = 1'b0;
        endcase
    end

    assign chan_event = cap_event || cmp_event;
    // armed by a read while set; a new event disarms so the write cannot clear
    assign flag_clear = wr_sc && armed_ff && !WDATA[chan_pkg::SC_FLAG];

    always_comb begin
        nxt_flag = flag_ff;
        if (flag_clear) begin
            nxt_flag = 1'b0;
        end
        if (chan_event) begin
            nxt_flag = 1'b1;
        end
        nxt_ie = wr_sc ? WDATA[chan_pkg::SC_IE] : ie_ff;
        nxt_stat = stat_ff;
        if (WR && (ADDR == chan_pkg::OFS_IRQ_STAT) && WDATA[chan_pkg::ST_EVENT]) begin
            nxt_stat = 1'b0;
        end
        if (chan_event) begin
            nxt_stat = 1'b1;
        end
        nxt_mask = (WR && (ADDR == chan_pkg::OFS_IRQ_MASK)) ? WDATA[chan_pkg::ST_EVENT] : mask_ff;
    end

    // event flag and clear handshake
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            flag_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            if (chan_event) begin
                armed_ff <= 1'b0;
            end else if (rd_sc && flag_ff) begin
                armed_ff <= 1'b1;
            end else if (wr_sc) begin
                armed_ff <= 1'b0;
            end
        end
    end

    // channel control fields
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ie_ff <= chan_pkg::SC_RESET[chan_pkg::SC_IE];
            msu_ff <= chan_pkg::SC_RESET[chan_pkg::SC_MSU];
            msl_ff <= chan_pkg::SC_RESET[chan_pkg::SC_MSL];
            els_ff <= chan_pkg::SC_RESET[chan_pkg::SC_ELSU:chan_pkg::SC_ELSL];
        end else begin
            ie_ff <= nxt_ie;
            if (wr_sc) begin
                msu_ff <= WDATA[chan_pkg::SC_MSU];
                msl_ff <= WDATA[chan_pkg::SC_MSL];
                els_ff <= WDATA[chan_pkg::SC_ELSU:chan_pkg::SC_ELSL];
            end
        end
    end

    // module-wide center-aligned select
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cas_ff <= chan_pkg::MODCTL_RESET[chan_pkg::MC_CAS];
            up_down_ff <= 1'b0;
        end else begin
            if (WR && (ADDR == chan_pkg::OFS_MODCTL)) begin
                cas_ff <= WDATA[chan_pkg::MC_CAS];
                up_down_ff <= WDATA[chan_pkg::MC_CAS];
            end
        end
    end

    // sticky status and mask
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            stat_ff <= 1'b0;
            mask_ff <= 1'b0;
            chan_irq_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            chan_irq_ff <= nxt_flag && nxt_ie;
            irq_ff <= nxt_stat && nxt_mask;
        end
    end

    // channel value, capture load and write latching
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            value_ff <= chan_pkg::VALUE_RESET;
            wbuf_lo_ff <= 8'h00;
            wbuf_hi_ff <= 8'h00;
            wlo_seen_ff <= 1'b0;
            whi_seen_ff <= 1'b0;
        end else if (cap_event) begin
            value_ff <= COUNT;
        end else if (wr_sc) begin
            wlo_seen_ff <= 1'b0;
            whi_seen_ff <= 1'b0;
        end else if (mode != chan_pkg::MODE_CAPTURE) begin
            // captures own the value; writes only count outside capture
            if (WR && (ADDR == chan_pkg::OFS_VAL_LO)) begin
                wbuf_lo_ff <= WDATA;
                wlo_seen_ff <= 1'b1;
            end else if (WR && (ADDR == chan_pkg::OFS_VAL_HI)) begin
                wbuf_hi_ff <= WDATA;
                whi_seen_ff <= 1'b1;
            end else if (wlo_seen_ff && whi_seen_ff) begin
                value_ff <= {wbuf_hi_ff, wbuf_lo_ff};
                wlo_seen_ff <= 1'b0;
                whi_seen_ff <= 1'b0;
            end
        end
    end

    // coherent read latching of the value pair
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rbuf_ff <= 8'h00;
            rlatched_ff <= 1'b0;
            rlatch_hi_ff <= 1'b0;
        end else if (wr_sc) begin
            rlatched_ff <= 1'b0;
        end else if (RD && (ADDR == chan_pkg::OFS_VAL_LO || ADDR == chan_pkg::OFS_VAL_HI)) begin
            if (!rlatched_ff) begin
                rlatched_ff <= 1'b1;
                rlatch_hi_ff <= (ADDR == chan_pkg::OFS_VAL_LO);
                rbuf_ff <= (ADDR == chan_pkg::OFS_VAL_LO) ? value_ff[15:8] : value_ff[7:0];
            end else if ((ADDR == chan_pkg::OFS_VAL_HI) == rlatch_hi_ff) begin
                rlatched_ff <= 1'b0;
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rdata_ff <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                chan_pkg::OFS_SC: rdata_ff <= sc_view;
                chan_pkg::OFS_MODCTL: rdata_ff <= {2'h0, cas_ff, 5'h00};
                chan_pkg::OFS_VAL_LO: rdata_ff <= (rlatched_ff && !rlatch_hi_ff) ? rbuf_ff : value_ff[7:0];
                chan_pkg::OFS_VAL_HI: rdata_ff <= (rlatched_ff && rlatch_hi_ff) ? rbuf_ff : value_ff[15:8];
                chan_pkg::OFS_IRQ_STAT: rdata_ff <= {7'h00, stat_ff};
                chan_pkg::OFS_IRQ_MASK: rdata_ff <= {7'h00, mask_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // pin synchroniser; the level moves once stages two and three agree
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            pin_lvl_ff <= 1'b0;
        end else begin
            sync1_ff <= PIN_IN;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                pin_lvl_ff <= sync3_ff;
            end
        end
    end

    // pin drive per mode
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            unique case (mode)
                chan_pkg::MODE_GPIO, chan_pkg::MODE_CAPTURE: pin_oe_ff <= 1'b0;
                chan_pkg::MODE_COMPARE: begin
                    pin_oe_ff <= 1'b1;
                    if (match) begin
                        unique case (els_ff)
                            chan_pkg::ELS_RISE: pin_out_ff <= !pin_out_ff;
                            chan_pkg::ELS_FALL: pin_out_ff <= 1'b0;
                            default: pin_out_ff <= 1'b1;
                        endcase
                    end
                end
                chan_pkg::MODE_EPWM: begin
                    pin_oe_ff <= 1'b1;
                    if (extreme_duty) begin
                        pin_out_ff <= (value_ff == 16'h0000) ? els_ff[0] : !els_ff[0];
                    end else if (match) begin
                        pin_out_ff <= els_ff[0];
                    end else if (COUNT_TICK && COUNT == 16'h0000) begin
                        pin_out_ff <= !els_ff[0];
                    end
                end
                chan_pkg::MODE_CPWM: begin
                    pin_oe_ff <= 1'b1;
                    if (extreme_duty) begin
                        pin_out_ff <= (value_ff == 16'h0000) ? els_ff[0] : !els_ff[0];
                    end else if (match) begin
                        pin_out_ff <= COUNT_UP ? els_ff[0] : !els_ff[0];
                    end
                end
            endcase
        end
    end

    assign RDATA = rdata_ff;
    assign PIN_OUT = pin_out_ff;
    assign PIN_OE = pin_oe_ff;
    assign CHAN_IRQ = chan_irq_ff;
    assign IRQ = irq_ff;
    assign UP_DOWN_MODE = up_down_ff;

endmodule

`default_nettype wire

// ==== verification/timer_channel_control_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_channel_control_monitor (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // register port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // counter, pin and interrupts
    input wire logic COUNT_TICK,
    input wire logic UP_DOWN_MODE,
    input wire logic PIN_OUT,
    input wire logic PIN_OE,
    input wire logic CHAN_IRQ,
    input wire logic IRQ
);
    // shadows of written control bits; age_ff counts cycles since a mode or value write
    logic [4:0] sc_ff;
    logic cas_ff;
    logic mask_ff;
    logic [2:0] age_ff;
    wire logic quiet = age_ff == 3'h4;
    wire logic drv = quiet && sc_ff[1:0] != 2'h0 && (cas_ff || sc_ff[3:2] != 2'h0);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            age_ff <= 3'h4;
        end else if (WR && ADDR < 3'h4) begin
            age_ff <= 3'h0;
        end else if (!quiet) begin
            age_ff <= age_ff + 3'h1;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sc_ff <= 5'h00;
            cas_ff <= 1'b0;
            mask_ff <= 1'b0;
        end else if (WR) begin
            sc_ff <= (ADDR == 3'h0) ? WDATA[6:2] : sc_ff;
            cas_ff <= (ADDR == 3'h1) ? WDATA[5] : cas_ff;
            mask_ff <= (ADDR == 3'h5) ? WDATA[0] : mask_ff;
        end
    end
    sequence s_flag_seen;
        RD && ADDR == 3'h0 && sc_ff[4] && $past(sc_ff[4]) ##1 RDATA[7];
    endsequence
    property p_gpio;
        quiet && sc_ff[1:0] == 2'h0 |-> !PIN_OE;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin driven while released");
    property p_drive;
        drv |-> PIN_OE;
    endproperty
    a_drive: assert property (p_drive) else $error("pin not driven");
    property p_tick;
        drv && $changed(PIN_OUT) |-> $past(COUNT_TICK);
    endproperty
    a_tick: assert property (p_tick) else $error("pin moved without tick");
    property p_ie;
        CHAN_IRQ |-> sc_ff[4] || $past(sc_ff[4]);
    endproperty
    a_ie: assert property (p_ie) else $error("irq with enable off");
    property p_flag_irq;
        s_flag_seen |-> CHAN_IRQ;
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("flag set, no irq");
    property p_mask;
        IRQ |-> mask_ff || $past(mask_ff);
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_updown;
        cas_ff == $past(cas_ff) |-> UP_DOWN_MODE == cas_ff;
    endproperty
    a_updown: assert property (p_updown) else $error("up/down mode wrong");
    property p_reset;
        $past(SRST) |-> !(PIN_OE || CHAN_IRQ || IRQ || UP_DOWN_MODE) && RDATA == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("output set after reset");
endmodule
bind timer_channel_control timer_channel_control_monitor mon (
    .REF_CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .COUNT_TICK,
    .UP_DOWN_MODE, .PIN_OUT, .PIN_OE, .CHAN_IRQ, .IRQ
);
`default_nettype wire

// ==== verification/chan_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module chan_far_side (
    // clock, reset and bench control
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic up_down,
    input wire logic [15:0] modulo,
    // shared counter seen by the channel
    output logic [15:0] count,
    output logic tick,
    output logic up
);
    // one tick per running cycle; turns at modulo and zero when counting up/down
    always_ff @(posedge clk) begin
        tick <= run && !srst;
        if (srst) begin
            count <= 16'h0000;
            up <= 1'b1;
        end else if (run && !up_down) begin
            up <= 1'b1;
            count <= (count == modulo) ? 16'h0000 : count + 16'h0001;
        end else if (run) begin
            up <= up ? count != modulo : count == 16'h0000;
            count <= (up ? count != modulo : count == 16'h0000) ? count + 16'h0001 : count - 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== verification/timer_channel_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_channel_control_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic run = 1'b0;
    logic ext = 1'b0;
    logic [15:0] modulo = 16'h000f;
    logic [7:0] rdata, d, cfg;
    logic [15:0] count, v;
    logic tick, cnt_up, udm, pin_in, pin_out, pin_oe, chan_irq, irq, p0;
    logic [1:0] e;
    logic [31:0] seed = 32'h18d3;
    int bad_count = 0;
    int num_checks = 0;
    // pin wire: channel drive wins, else the outside level
    assign pin_in = pin_oe ? pin_out : ext;
    timer_channel_control uut (
        .REF_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re), .RDATA(rdata),
        .COUNT(count), .COUNT_TICK(tick), .COUNT_UP(cnt_up), .MODULO(modulo), .UP_DOWN_MODE(udm),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CHAN_IRQ(chan_irq), .IRQ(irq)
    );
    chan_far_side far (
        .clk(clk), .srst(srst), .run(run), .up_down(udm), .modulo(modulo),
        .count(count), .tick(tick), .up(cnt_up)
    );
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 x = rdata;
    endtask
    // read flag, then clear it with a write of zero and confirm
    task automatic flag_exp(input logic f, input logic [7:0] c);
        reg_rd(3'h0, d);
        chk(16'(d), 16'({f, c[6:0]}), "flag");
        chk(16'(chan_irq), 16'(f & c[6]), "chan irq");
        reg_wr(3'h0, c);
        reg_rd(3'h0, d);
        chk(16'(d), 16'(c), "flag clear");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            reg_rd(i[2:0], d);
            chk(16'(d), 16'h0000, "reset read");
        end
        repeat (4) begin
            cfg = 8'((rnd() | 32'h80) & 32'hf3);
            reg_wr(3'h0, cfg);
            reg_rd(3'h0, d);
            chk(16'(d), 16'(cfg & 8'h70), "sc readback");
        end
        // capture with the counter frozen, so the captured value is known
        for (int i = 1; i < 4; i++) begin
            e = i[1:0];
            cfg = {4'h4, e, 2'h0};
            reg_wr(3'h0, cfg);
            run <= 1'b1;
            repeat (1 + rnd() % 9) @(posedge clk);
            run <= 1'b0;
            ext <= 1'b1;
            repeat (8) @(posedge clk);
            reg_rd(3'h2, v[7:0]);
            reg_rd(3'h3, v[15:8]);
            if (e[0]) chk(v, count, "capture value");
            flag_exp(e[0], cfg);
            ext <= 1'b0;
            repeat (8) @(posedge clk);
            flag_exp(e[1], cfg);
        end
        reg_wr(3'h4, 8'h01);
        reg_wr(3'h5, 8'h01);
        chk(16'(irq), 16'h0000, "irq before event");
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(irq), 16'h0001, "irq");
        reg_wr(3'h0, cfg);
        reg_rd(3'h0, d);
        chk(16'(d), 16'(cfg | 8'h80), "clear unarmed");
        ext <= 1'b0;
        repeat (8) @(posedge clk);
        reg_wr(3'h0, cfg);
        flag_exp(1'b1, cfg);
        reg_wr(3'h4, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk(16'(irq), 16'h0000, "irq clear");
        for (int i = 1; i < 4; i++) begin
            e = i[1:0];
            cfg = {4'h5, e, 2'h0};
            reg_wr(3'h0, cfg);
            reg_wr(3'h3, 8'hff);
            reg_wr(3'h0, cfg);
            v = 16'(rnd() % 14 + 1);
            reg_wr(3'h2, v[7:0]);
            reg_wr(3'h3, v[15:8]);
            repeat (2) @(posedge clk);
            #1 p0 = pin_out;
            run <= 1'b1;
            repeat (16) @(posedge clk);
            run <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk(16'(pin_out), 16'(e == 2'h1 ? !p0 : e[0]), "compare pin");
            flag_exp(1'b1, cfg);
        end
        // edge high, edge low, 0%, 100%, center-aligned with capture mode bits
        for (int i = 0; i < 5; i++) begin
            e = (i == 1) ? 2'h1 : 2'h2;
            v = (i == 2) ? 16'h0000 : (i == 3) ? 16'h0014 : 16'(rnd() % 14 + 1);
            reg_wr(3'h1, (i == 4) ? 8'h20 : 8'h00);
            cfg = {2'h1, i != 4, 1'b0, e, 2'h0};
            reg_wr(3'h0, cfg);
            reg_wr(3'h2, v[7:0]);
            reg_wr(3'h3, v[15:8]);
            run <= 1'b1;
            repeat (40 + rnd() % 9) @(posedge clk);
            run <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk(16'(udm), 16'(i == 4), "up/down");
            if (count != v) chk(16'(pin_out), 16'((count < v) ^ e[0]), "pwm pin");
            flag_exp(i < 2 || i == 4, cfg);
        end
        reg_wr(3'h1, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
